// ### ashc_arg_check.sv
/*
 Combinational argument check of one start command.
 Assumes the caller registers the result and applies the priority of commands.
*/
`timescale 1ns/1ps
module ashc_arg_check (
   input wire logic is_dual,           // Dual-axis start, else home-return
   input wire logic dev_ok,            // Operand device type permitted
   input wire logic in_use,            // All addressed axes configured in use
   input wire logic home_none,         // Addressed axis has no homing method
   input wire logic [15:0] num1,       // Axis 1 data number
   input wire logic [15:0] num2,       // Axis 2 data number
   input wire logic [15:0] home_type,  // Home-return type word
   output logic err,                   // Operation error
   output logic [15:0] code,           // Code to post with it
   output logic range_bad              // Home-return control data out of range
);
   function automatic logic num_ok(input logic [15:0] n);
      num_ok = (n >= ashc_pkg::DATA_NUM_MIN) && (n <= ashc_pkg::DATA_NUM_MAX);
   endfunction

   always_comb begin
      err = 1'b1;
      code = ashc_pkg::ERR_CODE_RESET;
      range_bad = 1'b0;
      if (!dev_ok) begin
         code = ashc_pkg::ERR_DEVICE;
      end else if (!in_use) begin
         code = ashc_pkg::ERR_UNUSED;
      end else if (is_dual && !(num_ok(num1) && num_ok(num2))) begin
         code = ashc_pkg::ERR_RANGE;
      end else if (!is_dual && home_none) begin
         code = ashc_pkg::ERR_UNUSED;
      end else begin
         err = 1'b0;
         // Bad type is an axis fault, not an operation error
         range_bad = !is_dual && ((home_type < ashc_pkg::HOME_MACHINE) ||
                                  (home_type > ashc_pkg::HOME_FAST_STANDBY));
      end
   end
endmodule // ashc_arg_check

// ### ashc_axis.sv
/*
 Flag sequencer of one axis: busy, completion, homing request/done, fault.
 Assumes the drive pulses move_done when the move or the decel stop ends.
*/
`timescale 1ns/1ps
module ashc_axis (
   input wire logic core_clk,                      // Core clock
   input wire logic sys_rst,                       // Async reset
   input wire logic start,                         // Accepted start pulse
   input wire ashc_pkg::ashc_move_kind_t kind,     // Kind of the started move
   input wire logic range_fault,                   // Rejected for bad control data
   input wire logic halt,                          // Stop command
   input wire logic fault_det,                     // Error detected by the drive
   input wire logic move_done,                     // Drive reports motion ended
   output ashc_pkg::ashc_axis_flags_t flags,       // Axis flags
   output logic decel_req                          // Decelerate-to-stop request
);
   typedef enum logic [1:0] {AX_IDLE, AX_RUN, AX_STOP} ashc_ax_state_t;
   ashc_ax_state_t state_reg;
   logic mach_reg;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= AX_IDLE;
         flags <= '0;
         mach_reg <= 1'b0;
         decel_req <= 1'b0;
      end else begin
         decel_req <= 1'b0;
         if (range_fault) flags.fault <= 1'b1;
         unique case (state_reg)
            AX_IDLE: if (start) begin
               state_reg <= AX_RUN;
               flags.busy <= 1'b1;
               flags.done <= 1'b0;
               flags.home_done <= 1'b0;
               flags.fault <= 1'b0;
               mach_reg <= (kind == ashc_pkg::ASHC_MV_HOME_MACH);
               if (kind == ashc_pkg::ASHC_MV_HOME_MACH) flags.home_req <= 1'b1;
            end
            AX_RUN: if (halt || fault_det) begin
               // Completion stays clear on an aborted move
               state_reg <= AX_STOP;
               decel_req <= 1'b1;
            end else if (move_done) begin
               state_reg <= AX_IDLE;
               flags.busy <= 1'b0;
               flags.done <= 1'b1;
               if (mach_reg) begin
                  flags.home_req <= 1'b0;
                  flags.home_done <= 1'b1;
               end
            end
            AX_STOP: begin
               decel_req <= 1'b1;
               if (move_done) begin
                  state_reg <= AX_IDLE;
                  flags.busy <= 1'b0;
                  decel_req <= 1'b0;
               end
            end
         endcase
      end
   end
endmodule // ashc_axis

// ### ashc_drive_model.sv
/*
 Behavioural drive of both axes: answers each move start with a move_done pulse.
 Assumes move_start and decel_stop_req come from the control block on core_clk.
*/
`timescale 1ns/1ps
module ashc_drive_model #(
   parameter int LAT1 = 6, // Axis 1 move length in cycles
   parameter int LAT2 = 12 // Axis 2 move length, longer so the axes finish apart
) (
   input wire logic core_clk, // Core clock
   input wire logic sys_rst, // Async reset
   input wire logic [1:0] move_start, // Move start pulses
   input wire logic [1:0] decel_stop_req, // Decelerate requests
   output logic [1:0] move_done // End of motion pulses
);
   // ==========================================
   // Motion timers
   int cnt [2];
   logic [1:0] decel_seen;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= '{0, 0};
         decel_seen <= 2'h0;
         move_done <= 2'h0;
      end else begin
         decel_seen <= decel_stop_req;
         for (int i = 0; i < 2; i++) begin
            move_done[i] <= (cnt[i] == 1);
            if (move_start[i]) cnt[i] <= (i == 0) ? LAT1 : LAT2;
            // A stop reloads the remaining move with a 3-cycle deceleration
            else if (decel_stop_req[i] && !decel_seen[i]) cnt[i] <= 3;
            else if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
         end
      end
   end
endmodule // ashc_drive_model

// ### ashc_pkg.sv
/*
 Shared constants and types of the two-axis start and home-return control.
 Assumes a single core clock domain and command pulses one cycle wide.
*/
package ashc_pkg;
   // ==========================================
   // Error codes posted in the error code word
   localparam logic [15:0] ERR_RANGE = 16'h1004;  // 4100
   localparam logic [15:0] ERR_DEVICE = 16'h1005; // 4101
   localparam logic [15:0] ERR_UNUSED = 16'h1014; // 4116
   localparam logic [15:0] ERR_CODE_RESET = 16'h0000;

   // ==========================================
   // Argument ranges
   localparam logic [15:0] DATA_NUM_MIN = 16'h0001;
   localparam logic [15:0] DATA_NUM_MAX = 16'h000A;
   localparam logic [15:0] HOME_MACHINE = 16'h0001;
   localparam logic [15:0] HOME_FAST_ORIGIN = 16'h0002;
   localparam logic [15:0] HOME_FAST_STANDBY = 16'h0003;
   localparam logic [31:0] TARGET_NONE = 32'h0000_0000;

   // ==========================================
   // Types
   typedef enum logic [1:0] {
      ASHC_MV_TABLE,
      ASHC_MV_HOME_MACH,
      ASHC_MV_HOME_ORIGIN,
      ASHC_MV_HOME_STANDBY
   } ashc_move_kind_t;

   typedef struct packed {
      logic [15:0] home_type;
      logic [31:0] standby_addr;
   } ashc_home_ctl_t;

   typedef struct packed {
      ashc_move_kind_t kind;
      logic [15:0] data_number;
      logic [31:0] target;
   } ashc_move_req_t;

   typedef struct packed {
      logic busy;
      logic done;
      logic home_req;
      logic home_done;
      logic fault;
   } ashc_axis_flags_t;
endpackage

// ### ashc_top.sv
/*
 Two-axis start and home-return control: argument checks, error posting,
 per-axis flags and move requests to the drive.
 Assumes command pulses one cycle wide and synchronous to core_clk; the
 drive answers each started move with one move_done pulse.
*/
// Overview of operation
// - Forbidden operand device type raises error flag with code 4101.
// - Axis not configured in use rejects the command with code 4116.
// - Dual start data numbers must be 1 to 10, else code 4100.
// - Successful dual start begins both axes together and sets both busy flags.
// - Each axis clears busy and sets completion when its own move finishes.
// - Completion stays set until that axis is next started.
// - Stop or detected error decelerates the axis; completion stays clear.
// - Home-return type word: 1 machine, 2 fast to origin, 3 fast to standby.
// - Signed 32-bit standby address used only for type 3.
// - Machine homing start sets busy and homing request.
// - Machine homing end clears busy, request; sets completion and homing done.
// - Homing done clears when the axis is next started.
// - Out-of-range homing control data sets axis fault and does not start.
// - Stop or error during machine homing leaves homing done clear.
// - Fast homing sets only busy; end sets completion; request untouched.
// - Stop or error during fast homing leaves completion clear.
// - Homing method none makes a home-return start fail with 4116.
`timescale 1ns/1ps
module ashc_top #(
   parameter int NUM_AXES = 2                     // Axes served
) (
   input wire logic core_clk,                     // Core clock, 200 MHz
   input wire logic sys_rst,                      // Async reset, active high
   input wire logic dual_axis_start_cmd,          // Dual-axis start pulse
   input wire logic [15:0] axis1_data_number,     // Axis 1 data number
   input wire logic [15:0] axis2_data_number,     // Axis 2 data number
   input wire logic axis1_homing_start_cmd,       // Axis 1 home-return pulse
   input wire logic axis2_homing_start_cmd,       // Axis 2 home-return pulse
   input wire ashc_pkg::ashc_home_ctl_t home_ctl, // Home-return control words
   input wire logic operand_dev_ok,               // Operand device type permitted
   input wire logic [1:0] axis_in_use,            // Positioning configured in use
   input wire logic [1:0] homing_method_none,     // Homing method set to none
   input wire logic [1:0] axis_halt_cmd,          // Stop command per axis
   input wire logic [1:0] axis_fault_detect,      // Drive error per axis
   input wire logic [1:0] move_done,              // Drive motion ended per axis
   input wire logic error_flag_clear,             // Clears the error flag
   output logic operation_error_flag,             // Sticky operation error
   output logic [15:0] error_code_word,           // Last error code
   output logic axis1_busy_flag,                  // Axis 1 busy
   output logic axis1_done_flag,                  // Axis 1 positioning complete
   output logic axis1_homing_request,             // Axis 1 homing request
   output logic axis1_homing_done,                // Axis 1 homing complete
   output logic axis1_fault_flag,                 // Axis 1 fault
   output logic axis2_busy_flag,                  // Axis 2 busy
   output logic axis2_done_flag,                  // Axis 2 positioning complete
   output logic axis2_homing_request,             // Axis 2 homing request
   output logic axis2_homing_done,                // Axis 2 homing complete
   output logic axis2_fault_flag,                 // Axis 2 fault
   output logic [1:0] move_start,                 // Move start pulse per axis
   output ashc_pkg::ashc_move_req_t axis1_move,   // Axis 1 move request
   output ashc_pkg::ashc_move_req_t axis2_move,   // Axis 2 move request
   output logic [1:0] decel_stop_req              // Decelerate request per axis
);
   // ==========================================
   // Command selection
   // Dual start wins over homing; a losing pulse in the same cycle is dropped.
   logic cmd_any;
   logic is_dual;
   logic home_axis;
   logic chk_in_use;
   logic chk_home_none;
   logic chk_err;
   logic [15:0] chk_code;
   logic chk_range_bad;
   logic [1:0] axis_busy;
   logic axes_free;
   logic accept;
   logic [1:0] start_vec;
   logic [1:0] range_fault_vec;
   ashc_pkg::ashc_move_kind_t home_kind;
   logic [31:0] home_target;
   ashc_pkg::ashc_axis_flags_t flags [NUM_AXES];
   logic [1:0] decel_vec;
   logic op_err_reg;
   logic [15:0] err_code_reg;
   logic [1:0] move_start_reg;
   ashc_pkg::ashc_move_req_t move_reg [NUM_AXES];
   logic [1:0] decel_reg;

   assign is_dual = dual_axis_start_cmd;
   assign cmd_any = dual_axis_start_cmd || axis1_homing_start_cmd || axis2_homing_start_cmd;
   assign home_axis = !axis1_homing_start_cmd;
   assign chk_in_use = is_dual ? (&axis_in_use) : axis_in_use[home_axis];
   assign chk_home_none = homing_method_none[home_axis];

   ashc_arg_check u_check (
      .is_dual(is_dual),
      .dev_ok(operand_dev_ok),
      .in_use(chk_in_use),
      .home_none(chk_home_none),
      .num1(axis1_data_number),
      .num2(axis2_data_number),
      .home_type(home_ctl.home_type),
      .err(chk_err),
      .code(chk_code),
      .range_bad(chk_range_bad)
   );

   // A start that passes the checks but is aimed at a busy axis is ignored silently
   assign axes_free = is_dual ? !(|axis_busy) : !axis_busy[home_axis];
   assign accept = cmd_any && !chk_err && !chk_range_bad && axes_free;

   always_comb begin
      start_vec = 2'b00;
      range_fault_vec = 2'b00;
      if (accept) begin
         if (is_dual) start_vec = 2'b11;
         else start_vec[home_axis] = 1'b1;
      end
      if (cmd_any && !is_dual && !chk_err && chk_range_bad) begin
         range_fault_vec[home_axis] = 1'b1;
      end
   end

   // ==========================================
   // Home-return type decode
   always_comb begin
      home_kind = ashc_pkg::ASHC_MV_HOME_MACH;
      home_target = ashc_pkg::TARGET_NONE;
      unique case (home_ctl.home_type)
         ashc_pkg::HOME_FAST_ORIGIN: home_kind = ashc_pkg::ASHC_MV_HOME_ORIGIN;
         ashc_pkg::HOME_FAST_STANDBY: begin
            home_kind = ashc_pkg::ASHC_MV_HOME_STANDBY;
            home_target = home_ctl.standby_addr;
         end
         default: home_kind = ashc_pkg::ASHC_MV_HOME_MACH;
      endcase
   end

   // ==========================================
   // Axis sequencers
   genvar gi;
   generate
      for (gi = 0; gi < NUM_AXES; gi++) begin : g_axis
         ashc_axis u_axis (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .start(start_vec[gi]),
            .kind(is_dual ? ashc_pkg::ASHC_MV_TABLE : home_kind),
            .range_fault(range_fault_vec[gi]),
            .halt(axis_halt_cmd[gi]),
            .fault_det(axis_fault_detect[gi]),
            .move_done(move_done[gi]),
            .flags(flags[gi]),
            .decel_req(decel_vec[gi])
         );
         assign axis_busy[gi] = flags[gi].busy;

         // Move request to the drive, launched with the busy flag
         always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
               move_start_reg[gi] <= 1'b0;
               move_reg[gi] <= '0;
               decel_reg[gi] <= 1'b0;
            end else begin
               move_start_reg[gi] <= start_vec[gi];
               decel_reg[gi] <= decel_vec[gi];
               if (start_vec[gi]) begin
                  move_reg[gi].kind <= is_dual ? ashc_pkg::ASHC_MV_TABLE : home_kind;
                  move_reg[gi].data_number <= (gi == 0) ? axis1_data_number : axis2_data_number;
                  move_reg[gi].target <= is_dual ? ashc_pkg::TARGET_NONE : home_target;
               end
            end
         end
      end
   endgenerate

   // ==========================================
   // Operation error flag and code
   // The flag is sticky; a new error in the clearing cycle keeps it set.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         op_err_reg <= 1'b0;
      end else if (cmd_any && chk_err) begin
         op_err_reg <= 1'b1;
      end else if (error_flag_clear) begin
         op_err_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         err_code_reg <= ashc_pkg::ERR_CODE_RESET;
      end else if (cmd_any && chk_err) begin
         err_code_reg <= chk_code;
      end
   end

   // ==========================================
   // Outputs
   assign operation_error_flag = op_err_reg;
   assign error_code_word = err_code_reg;
   assign axis1_busy_flag = flags[0].busy;
   assign axis1_done_flag = flags[0].done;
   assign axis1_homing_request = flags[0].home_req;
   assign axis1_homing_done = flags[0].home_done;
   assign axis1_fault_flag = flags[0].fault;
   assign axis2_busy_flag = flags[1].busy;
   assign axis2_done_flag = flags[1].done;
   assign axis2_homing_request = flags[1].home_req;
   assign axis2_homing_done = flags[1].home_done;
   assign axis2_fault_flag = flags[1].fault;
   assign move_start = move_start_reg;
   assign axis1_move = move_reg[0];
   assign axis2_move = move_reg[1];
   assign decel_stop_req = decel_reg;

   // ==========================================
   // Assertions
   property p_dev_err;
      @(posedge core_clk) disable iff (sys_rst)
      (cmd_any && !operand_dev_ok) |=> (operation_error_flag && error_code_word == ashc_pkg::ERR_DEVICE);
   endproperty
   a_dev_err: assert property (p_dev_err) else $error("device error not posted");

   property p_unused_err;
      @(posedge core_clk) disable iff (sys_rst)
      (dual_axis_start_cmd && operand_dev_ok && !(&axis_in_use))
         |=> (operation_error_flag && error_code_word == ashc_pkg::ERR_UNUSED);
   endproperty
   a_unused_err: assert property (p_unused_err) else $error("unused axis not rejected");

   property p_range_err;
      @(posedge core_clk) disable iff (sys_rst)
      (dual_axis_start_cmd && operand_dev_ok && (&axis_in_use) &&
       (axis1_data_number > ashc_pkg::DATA_NUM_MAX || axis1_data_number < ashc_pkg::DATA_NUM_MIN))
         |=> (error_code_word == ashc_pkg::ERR_RANGE && move_start == 2'b00);
   endproperty
   a_range_err: assert property (p_range_err) else $error("data number range not checked");

   property p_dual_start;
      @(posedge core_clk) disable iff (sys_rst)
      (dual_axis_start_cmd && !chk_err && !(|axis_busy))
         |=> (axis1_busy_flag && axis2_busy_flag && move_start == 2'b11);
   endproperty
   a_dual_start: assert property (p_dual_start) else $error("dual start not simultaneous");

   property p_done_on_end;
      @(posedge core_clk) disable iff (sys_rst)
      $rose(axis2_done_flag) |-> ($fell(axis2_busy_flag) && $past(move_done[1]));
   endproperty
   a_done_on_end: assert property (p_done_on_end) else $error("completion not tied to own end");

   property p_done_clear_on_start;
      @(posedge core_clk) disable iff (sys_rst)
      start_vec[0] |=> (!axis1_done_flag && !axis1_homing_done) ##1 move_start[0] == 1'b0;
   endproperty
   a_done_clear_on_start: assert property (p_done_clear_on_start) else $error("flags not cleared at start");

   property p_halt_no_done;
      @(posedge core_clk) disable iff (sys_rst)
      (axis1_busy_flag && (axis_halt_cmd[0] || axis_fault_detect[0]) && !axis1_done_flag)
         |=> (!axis1_done_flag && !axis1_homing_done) ##1 decel_stop_req[0];
   endproperty
   a_halt_no_done: assert property (p_halt_no_done) else $error("aborted move reported complete");

   property p_standby_target;
      @(posedge core_clk) disable iff (sys_rst)
      (start_vec[0] && !is_dual) |=>
         (axis1_move.target == (($past(home_ctl.home_type) == ashc_pkg::HOME_FAST_STANDBY) ?
                                $past(home_ctl.standby_addr) : ashc_pkg::TARGET_NONE));
   endproperty
   a_standby_target: assert property (p_standby_target) else $error("standby address misused");

   property p_mach_start;
      @(posedge core_clk) disable iff (sys_rst)
      (start_vec[0] && !is_dual && home_ctl.home_type == ashc_pkg::HOME_MACHINE)
         |=> (axis1_busy_flag && axis1_homing_request);
   endproperty
   a_mach_start: assert property (p_mach_start) else $error("machine homing flags wrong");

   property p_mach_end;
      @(posedge core_clk) disable iff (sys_rst)
      $rose(axis1_homing_done) |-> (!axis1_homing_request && axis1_done_flag && !axis1_busy_flag);
   endproperty
   a_mach_end: assert property (p_mach_end) else $error("machine homing end flags wrong");

   property p_range_fault;
      @(posedge core_clk) disable iff (sys_rst)
      range_fault_vec[0] |=> (axis1_fault_flag && !move_start[0] && $stable(axis1_busy_flag));
   endproperty
   a_range_fault: assert property (p_range_fault) else $error("bad homing data not faulted");

   property p_fast_home;
      @(posedge core_clk) disable iff (sys_rst)
      (start_vec[0] && !is_dual && home_ctl.home_type != ashc_pkg::HOME_MACHINE)
         |=> (axis1_busy_flag && $stable(axis1_homing_request));
   endproperty
   a_fast_home: assert property (p_fast_home) else $error("fast homing touched request");

   property p_none_err;
      @(posedge core_clk) disable iff (sys_rst)
      (axis1_homing_start_cmd && !dual_axis_start_cmd && operand_dev_ok && axis_in_use[0] &&
       homing_method_none[0]) |=> (error_code_word == ashc_pkg::ERR_UNUSED && !move_start[0]);
   endproperty
   a_none_err: assert property (p_none_err) else $error("homing method none accepted");

   property p_reject_quiet;
      @(posedge core_clk) disable iff (sys_rst)
      (cmd_any && chk_err && !(|axis_busy))
         |=> (move_start == 2'b00 && !axis1_busy_flag && !axis2_busy_flag && $stable(axis1_done_flag));
   endproperty
   a_reject_quiet: assert property (p_reject_quiet) else $error("rejected command moved an axis");

   property p_done_on_end1;
      @(posedge core_clk) disable iff (sys_rst)
      $rose(axis1_done_flag) |-> ($fell(axis1_busy_flag) && $past(move_done[0]));
   endproperty
   a_done_on_end1: assert property (p_done_on_end1) else $error("axis 1 completion not own end");

   property p_halt_no_done2;
      @(posedge core_clk) disable iff (sys_rst)
      (axis2_busy_flag && (axis_halt_cmd[1] || axis_fault_detect[1]) && !axis2_done_flag)
         |=> (!axis2_done_flag && !axis2_homing_done) ##1 decel_stop_req[1];
   endproperty
   a_halt_no_done2: assert property (p_halt_no_done2) else $error("axis 2 aborted move completed");

   property p_standby_target2;
      @(posedge core_clk) disable iff (sys_rst)
      (start_vec[1] && !is_dual) |=>
         (axis2_move.target == (($past(home_ctl.home_type) == ashc_pkg::HOME_FAST_STANDBY) ?
                                $past(home_ctl.standby_addr) : ashc_pkg::TARGET_NONE));
   endproperty
   a_standby_target2: assert property (p_standby_target2) else $error("axis 2 standby misused");

   property p_range_fault2;
      @(posedge core_clk) disable iff (sys_rst)
      range_fault_vec[1] |=> (axis2_fault_flag && !move_start[1] && $stable(axis2_busy_flag));
   endproperty
   a_range_fault2: assert property (p_range_fault2) else $error("axis 2 bad data not faulted");

   property p_fast_home2;
      @(posedge core_clk) disable iff (sys_rst)
      (start_vec[1] && !is_dual && home_ctl.home_type != ashc_pkg::HOME_MACHINE)
         |=> (axis2_busy_flag && $stable(axis2_homing_request));
   endproperty
   a_fast_home2: assert property (p_fast_home2) else $error("axis 2 fast homing touched request");
endmodule // ashc_top

// ### ashc_top_tb.sv
/*
 Self-checking bench of the two-axis start and home-return control.
 Assumes outputs settle by the falling edge that follows the edge that takes a command.
*/
`timescale 1ns/1ps
module ashc_top_tb;
   logic core_clk = 0, sys_rst = 1, dual = 0, h1 = 0, h2 = 0, dev_ok = 1, clr = 0;
   logic [15:0] n1 = 16'h0001, n2 = 16'h000A;
   ashc_pkg::ashc_home_ctl_t hctl = '0;
   logic [1:0] in_use = 2'h3, hnone = 2'h0, halt = 2'h0, flt = 2'h0, mdone, mstart, decel;
   logic err, b1, d1, r1, hd1, f1, b2, d2, r2, hd2, f2;
   logic [15:0] code;
   ashc_pkg::ashc_move_req_t mv1, mv2;
   int num_errors = 0, n_compared = 0;
   always #2.5 core_clk = ~core_clk;
   ashc_top ashc_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .dual_axis_start_cmd(dual),
      .axis1_data_number(n1), .axis2_data_number(n2), .axis1_homing_start_cmd(h1),
      .axis2_homing_start_cmd(h2), .home_ctl(hctl), .operand_dev_ok(dev_ok), .axis_in_use(in_use),
      .homing_method_none(hnone), .axis_halt_cmd(halt), .axis_fault_detect(flt), .move_done(mdone),
      .error_flag_clear(clr), .operation_error_flag(err), .error_code_word(code),
      .axis1_busy_flag(b1), .axis1_done_flag(d1), .axis1_homing_request(r1), .axis1_homing_done(hd1),
      .axis1_fault_flag(f1), .axis2_busy_flag(b2), .axis2_done_flag(d2), .axis2_homing_request(r2),
      .axis2_homing_done(hd2), .axis2_fault_flag(f2), .move_start(mstart), .axis1_move(mv1),
      .axis2_move(mv2), .decel_stop_req(decel));
   ashc_drive_model ashc_drive_model_inst (.core_clk(core_clk), .sys_rst(sys_rst),
      .move_start(mstart), .decel_stop_req(decel), .move_done(mdone));
   // ==========================================
   // Tasks
   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [49:0] exp, input logic [49:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic pulse(input logic [2:0] which);
      @(negedge core_clk);
      {dual, h1, h2} = which;
      @(negedge core_clk);
      {dual, h1, h2} = 3'b000;
   endtask
   task automatic wait_for(input int axis1_only);
      int k;
      for (k = 0; k < 200 && (axis1_only ? b1 : (b1 || b2 || decel != 2'h0)); k++) @(negedge core_clk);
      if (k == 200) begin
         num_errors++;
         $display("[FAIL] wait for idle expected 0 seen 1");
         tally_and_finish();
      end
   endtask
   task automatic err_case(input string what, input logic [2:0] which, input logic [15:0] exp);
      pulse(which);
      chk(what, {33'h0, 1'b1, exp}, {33'h0, err, code});
      chk("flags", 50'h0, {44'h0, b1, b2, r1, hd1, mstart});
      clr = 1;
      @(negedge core_clk);
      clr = 0;
   endtask
   // ==========================================
   // Sequence
   initial begin
      repeat (20) @(negedge core_clk);
      sys_rst = 0;
      dev_ok = 0;
      err_case("bad device", 3'b100, 16'h1005);
      dev_ok = 1;
      in_use = 2'b10;
      err_case("not in use", 3'b100, 16'h1014);
      in_use = 2'h3;
      n1 = 16'h0000;
      err_case("number 0", 3'b100, 16'h1004);
      n1 = 16'h0001;
      n2 = 16'h000B;
      err_case("number 11", 3'b100, 16'h1004);
      n2 = 16'h000A;
      hnone = 2'b01;
      err_case("no method", 3'b010, 16'h1014);
      hnone = 2'h0;
      $display("test errors done");
      pulse(3'b100);
      chk("dual start", 50'hF, {46'h0, b1, b2, mstart});
      chk("numbers", {16'h0001, 16'h000A}, {mv1.data_number, mv2.data_number});
      wait_for(1);
      chk("axis1 first", 50'h6, {46'h0, b1, d1, b2, d2});
      wait_for(0);
      chk("both done", 50'h3, {48'h0, d1, d2});
      $display("test dual done");
      hctl = '{16'h0001, 32'h0000_1234};
      pulse(3'b010);
      chk("machine start", 50'h31, {44'h0, b1, r1, d1, hd1, mstart});
      chk("machine kind", {ashc_pkg::ASHC_MV_HOME_MACH, 32'h0}, {mv1.kind, mv1.target});
      wait_for(0);
      chk("machine end", 50'h5, {46'h0, b1, d1, r1, hd1});
      hctl.home_type = 16'h0002;
      pulse(3'b010);
      chk("fast start", 50'h8, {46'h0, b1, d1, r1, hd1});
      chk("fast kind", ashc_pkg::ASHC_MV_HOME_ORIGIN, mv1.kind);
      wait_for(0);
      chk("fast end", 50'h4, {46'h0, b1, d1, r1, hd1});
      hctl.home_type = 16'h0001;
      pulse(3'b010);
      halt = 2'b01;
      @(negedge core_clk);
      halt = 2'h0;
      @(negedge core_clk);
      chk("decel axis 1", 50'h1, decel);
      wait_for(0);
      chk("halted homing", 50'h0, {47'h0, b1, d1, hd1});
      $display("test homing axis 1 done");
      hctl = '{16'h0003, 32'hFFFF_FF9C};
      pulse(3'b001);
      chk("standby kind", {ashc_pkg::ASHC_MV_HOME_STANDBY, 32'hFFFF_FF9C}, {mv2.kind, mv2.target});
      flt = 2'b10;
      @(negedge core_clk);
      flt = 2'h0;
      @(negedge core_clk);
      chk("decel axis 2", 50'h2, decel);
      wait_for(0);
      chk("faulted fast", 50'h0, {48'h0, b2, d2});
      hctl.home_type = 16'h0004;
      pulse(3'b010);
      pulse(3'b001);
      chk("bad type", 50'h110, {41'h0, f1, b1, r2, hd2, f2, b2, mstart, err});
      $display("test homing axis 2 done");
      tally_and_finish();
   end
endmodule // ashc_top_tb
